// file: verilog/dpw_consts.svh
`ifndef DPW_CONSTS_SVH
`define DPW_CONSTS_SVH
// Behaviour
// - Each channel has 16-bit period and duty resolution.
// - Each channel has a prescaled 16-bit up-counter, readable, never writable.
// - Clearing timer_run (control bit 3) stops that channel's counter.
// - Counter equal to period: next increment clears it, output high if duty nonzero, cycle_flag set.
// - Period is (period_reg+1) times clock-division over 2 times prescale.
// - duty_reg copies into duty_latch at clear; output low on latch match.
// - duty_reg writable anytime; latch refreshes only after current latch matched.
// - High time is duty_reg times clock-division over 2 times prescale.
// - Normal and inverted outputs, enabled separately or as a pair.
// - Each output polarity follows its own active-level bit.
// - Dead time disabled: complementary outputs switch with no gap.
// - Dead time enabled and nonzero: outputs never active together.
// - A match that changes the output sets timer_match_flag that cycle.
// - Writing period low byte commits pending period, duty, dead time.
// - Committed values take effect at the next PWM cycle start.
// - Comparator falling edge shuts normal or both outputs when enabled.
// - Current comparator decision readable in cmp_result_bit.
// - Two-bit cmp_pin_select chooses comparator output pin function.
// - Comparator change sets cmp_irq_flag; interrupt only when enabled.
// - cmp_irq_flag cleared only by a software write.
// - Both enables keep comparator live in sleep; a change wakes device.

// Register indices (byte address is four times the index)
`define DPW_IDX_WAKE     7'h10
`define DPW_IDX_STATUS   7'h14
`define DPW_IDX_MASK     7'h1b
`define DPW_IDX_CMP1     7'h3a
`define DPW_IDX_CMP2     7'h3b
`define DPW_IDX_CMP3     7'h3c
`define DPW_IDX_CH_BASE  7'h40
`define DPW_IDX_CH_LAST  7'h4b
`define DPW_IDX_DEADCTL  7'h50
`define DPW_IDX_DEADVAL  7'h51
`define DPW_IDX_FLAGS    7'h52
`define DPW_IDX_CLKDIV   7'h53
// Sub-offsets inside a channel group of four
`define DPW_SUB_CTRL     2'h0
`define DPW_SUB_PERIOD   2'h1
`define DPW_SUB_DUTY     2'h2
`define DPW_SUB_TIMER    2'h3
// Field positions
`define DPW_BIT_CMP      6
`define DPW_BIT_RUN      3
`define DPW_BIT_SHDN     0
`define DPW_POS_PINSEL   4
`define DPW_POS_MATCHF   4
`define DPW_POS_DTEN     2
// Comparator pin select codes
`define DPW_PIN_RESULT   2'h1
`define DPW_PIN_INVERT   2'h2
// Reset value of the 16-bit counter, period and duty state
`define DPW_RST_ZERO     16'h0000
`endif

// file: verilog/dpw_pkg.sv
package dpw_pkg;
   // Per-channel control register layout
   typedef struct packed {
      logic       out_enable;
      logic       inv_out_enable;
      logic       out_active_level;
      logic       inv_active_level;
      logic       timer_run;
      logic [2:0] prescale;
   } dpw_chan_ctl_t;

   typedef logic [15:0] dpw_word_t;
endpackage

// file: verilog/dpw_top.sv
`include "dpw_consts.svh"

module dpw_top (
   // System
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Avalon-MM slave, byte address
   input  wire logic [8:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Comparator
   input  wire logic        cmp_in,
   input  wire logic        sleep_mode,
   output logic             cmp_output_pin,
   output logic             cmp_output_oe,
   output logic             cmp_irq,
   output logic             wake_req,
   // PWM pins
   output logic      [2:0]  pwm_o,
   output logic      [2:0]  pwm_oe,
   output logic      [2:0]  pwm_n_o,
   output logic      [2:0]  pwm_n_oe
);

   // Prescale terminal count: ratio 2^p
   function automatic logic [6:0] psc_mask(input logic [2:0] p);
      psc_mask = 7'(({7'h00, 1'b1} << p) - 8'h01);
   endfunction
   // Dead gap length in clocks, minus one; zero value gives no gap
   function automatic logic [10:0] dt_cycles(input logic [7:0] v, input logic [1:0] p);
      dt_cycles = (v == 8'h00) ? 11'h000 : 11'(({3'h0, v} << p) - 11'h001);
   endfunction
   // Channel number from a register index
   function automatic logic [1:0] chan_of(input logic [6:0] idx);
      chan_of = 2'((idx - `DPW_IDX_CH_BASE) >> 2);
   endfunction

   dpw_pkg::dpw_chan_ctl_t ctl_q [3];
   dpw_pkg::dpw_word_t     period_q [3];
   dpw_pkg::dpw_word_t     duty_q [3];
   dpw_pkg::dpw_word_t     cnt_q [3];
   dpw_pkg::dpw_word_t     per_act_q [3];
   dpw_pkg::dpw_word_t     duty_cmt_q [3];
   dpw_pkg::dpw_word_t     dl_q [3];
   logic [6:0]             psc_q [3];
   logic [7:0]             dt_act_q [3];
   logic [10:0]            dead_q [3];
   logic [2:0]             dl_hit_q;
   logic [2:0]             commit_q;
   logic [2:0]             pwm_q;
   logic [2:0]             pwm_prev_q;
   logic [2:0]             shut_q;
   logic [2:0]             cycle_flag_q;
   logic [2:0]             match_flag_q;
   logic [2:0]             shdn_en_q;
   logic [2:0]             dt_en_q;
   logic [1:0]             dt_psc_q;
   logic [7:0]             dt_val_q;
   logic                   clkdiv_q;
   logic                   half_q;
   logic [1:0]             pin_sel_q;
   logic                   cmp_ie_q;
   logic                   cmp_we_q;
   logic                   cmp_flag_q;
   logic                   cmp_res_q;
   logic                   ack_q;
   logic [6:0]  idx;
   logic        in_chan;
   logic [1:0]  ch;
   logic [1:0]  sub;
   logic        wr_go;
   logic        base_en;
   logic [2:0]  tick;
   logic [2:0]  clr_ev;
   logic [2:0]  fall_ev;
   logic [2:0]  commit_wr;
   logic        cmp_live;
   logic        cmp_chg;
   logic        cmp_fall;
   logic [31:0] rd_val;
   // Address decode
   assign idx     = address[8:2];
   assign in_chan = (idx >= `DPW_IDX_CH_BASE) && (idx <= `DPW_IDX_CH_LAST);
   assign ch      = chan_of(idx);
   assign sub     = idx[1:0];

   // One wait state per access; write lands on the released edge
   assign waitrequest = (read | write) & ~ack_q;
   assign wr_go       = write & ack_q & clk_en;
   always_ff @(posedge clock) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else if (clk_en) begin
         ack_q <= (read | write) & ~ack_q;
      end
   end

   // Base clock: every cycle, or every other with the division option
   assign base_en = clkdiv_q ? half_q : 1'b1;
   always_ff @(posedge clock) begin
      if (rst) begin
         half_q <= 1'b0;
      end else if (clk_en) begin
         half_q <= ~half_q;
      end
   end

   // Match events per channel
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         tick[c]      = ctl_q[c].timer_run & base_en
                        & (psc_q[c] >= psc_mask(ctl_q[c].prescale));
         clr_ev[c]    = tick[c] & (cnt_q[c] == per_act_q[c]);
         fall_ev[c]   = tick[c] & ~clr_ev[c] & (16'(cnt_q[c] + 16'h0001) == dl_q[c]);
         commit_wr[c] = wr_go & in_chan & (ch == 2'(c)) & (sub == `DPW_SUB_PERIOD)
                        & byteenable[0];
      end
   end

   // Counter, prescaler, commit and duty latch
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int c = 0; c < 3; c++) begin
            cnt_q[c]      <= `DPW_RST_ZERO;
            psc_q[c]      <= 7'h00;
            per_act_q[c]  <= `DPW_RST_ZERO;
            duty_cmt_q[c] <= `DPW_RST_ZERO;
            dl_q[c]       <= `DPW_RST_ZERO;
            dt_act_q[c]   <= 8'h00;
         end
         dl_hit_q <= 3'h7;
         commit_q <= 3'h0;
         pwm_q    <= 3'h0;
      end else if (clk_en) begin
         for (int c = 0; c < 3; c++) begin
            if (!ctl_q[c].timer_run) begin
               // Stopped: count cleared, settings tracked directly
               cnt_q[c]      <= `DPW_RST_ZERO;
               psc_q[c]      <= 7'h00;
               per_act_q[c]  <= period_q[c];
               duty_cmt_q[c] <= duty_q[c];
               dl_q[c]       <= duty_q[c];
               dt_act_q[c]   <= dt_val_q;
               dl_hit_q[c]   <= 1'b1;
               commit_q[c]   <= 1'b0;
               pwm_q[c]      <= 1'b0;
            end else begin
               if (commit_wr[c]) begin
                  commit_q[c] <= 1'b1;
               end
               if (base_en) begin
                  psc_q[c] <= tick[c] ? 7'h00 : 7'(psc_q[c] + 7'h01);
               end
               if (clr_ev[c]) begin
                  cnt_q[c] <= `DPW_RST_ZERO;
                  if (commit_q[c]) begin
                     // New cycle picks up committed values
                     per_act_q[c]  <= period_q[c];
                     duty_cmt_q[c] <= duty_q[c];
                     dt_act_q[c]   <= dt_val_q;
                     commit_q[c]   <= commit_wr[c];
                  end
                  if (dl_hit_q[c]) begin
                     dl_q[c]     <= commit_q[c] ? duty_q[c] : duty_cmt_q[c];
                     dl_hit_q[c] <= ((commit_q[c] ? duty_q[c] : duty_cmt_q[c]) == 16'h0000);
                     pwm_q[c]    <= ((commit_q[c] ? duty_q[c] : duty_cmt_q[c]) != 16'h0000);
                  end else begin
                     pwm_q[c] <= (dl_q[c] != 16'h0000);
                  end
               end else if (tick[c]) begin
                  cnt_q[c] <= 16'(cnt_q[c] + 16'h0001);
                  if (fall_ev[c]) begin
                     pwm_q[c]    <= 1'b0;
                     dl_hit_q[c] <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // Dead-time gap counter
   always_ff @(posedge clock) begin
      if (rst) begin
         pwm_prev_q <= 3'h0;
         for (int c = 0; c < 3; c++) begin
            dead_q[c] <= 11'h000;
         end
      end else if (clk_en) begin
         pwm_prev_q <= pwm_q;
         for (int c = 0; c < 3; c++) begin
            if (pwm_q[c] != pwm_prev_q[c]) begin
               dead_q[c] <= dt_cycles(dt_act_q[c], dt_psc_q);
            end else if (dead_q[c] != 11'h000) begin
               dead_q[c] <= 11'(dead_q[c] - 11'h001);
            end
         end
      end
   end

   // Fault shutdown latch, released by stopping the channel
   always_ff @(posedge clock) begin
      if (rst) begin
         shut_q <= 3'h0;
      end else if (clk_en) begin
         for (int c = 0; c < 3; c++) begin
            if (!ctl_q[c].timer_run) begin
               shut_q[c] <= 1'b0;
            end else if (cmp_fall && shdn_en_q[c]) begin
               shut_q[c] <= 1'b1;
            end
         end
      end
   end

   // Pin drivers
   always_ff @(posedge clock) begin
      if (rst) begin
         pwm_o    <= 3'h0;
         pwm_oe   <= 3'h0;
         pwm_n_o  <= 3'h0;
         pwm_n_oe <= 3'h0;
      end else if (clk_en) begin
         for (int c = 0; c < 3; c++) begin
            logic gap;
            logic act;
            logic act_n;
            gap   = dt_en_q[c] & (dt_act_q[c] != 8'h00)
                    & ((pwm_q[c] != pwm_prev_q[c]) | (dead_q[c] != 11'h000));
            act   = pwm_q[c] & ~gap & ~shut_q[c];
            act_n = ctl_q[c].timer_run & ~pwm_q[c] & ~gap
                    & ~(shut_q[c] & ctl_q[c].inv_active_level);
            pwm_oe[c]   <= ctl_q[c].out_enable;
            pwm_n_oe[c] <= ctl_q[c].inv_out_enable;
            pwm_o[c]    <= ctl_q[c].out_enable
                           & (act ~^ ctl_q[c].out_active_level);
            pwm_n_o[c]  <= ctl_q[c].inv_out_enable
                           & (act_n ~^ ctl_q[c].inv_active_level);
         end
      end
   end

   // Timer flags: set wins over write-one-to-clear
   always_ff @(posedge clock) begin
      if (rst) begin
         cycle_flag_q <= 3'h0;
         match_flag_q <= 3'h0;
      end else if (clk_en) begin
         for (int c = 0; c < 3; c++) begin
            if (clr_ev[c]) begin
               cycle_flag_q[c] <= 1'b1;
            end else if (wr_go && idx == `DPW_IDX_FLAGS && byteenable[0] && writedata[c]) begin
               cycle_flag_q[c] <= 1'b0;
            end
            if ((clr_ev[c] & ~pwm_q[c]) | (fall_ev[c] & pwm_q[c])) begin
               match_flag_q[c] <= 1'b1;
            end else if (wr_go && idx == `DPW_IDX_FLAGS && byteenable[0]
                         && writedata[`DPW_POS_MATCHF + c]) begin
               match_flag_q[c] <= 1'b0;
            end
         end
      end
   end

   // Comparator decision, change and falling edge
   assign cmp_live = ~sleep_mode | (cmp_ie_q & cmp_we_q);
   assign cmp_chg  = cmp_live & (cmp_in != cmp_res_q);
   assign cmp_fall = cmp_chg & cmp_res_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         cmp_res_q      <= 1'b0;
         cmp_flag_q     <= 1'b0;
         cmp_irq        <= 1'b0;
         wake_req       <= 1'b0;
         cmp_output_pin <= 1'b0;
         cmp_output_oe  <= 1'b0;
      end else if (clk_en) begin
         if (cmp_live) begin
            cmp_res_q <= cmp_in;
         end
         if (cmp_chg) begin
            cmp_flag_q <= 1'b1;
         end else if (wr_go && idx == `DPW_IDX_STATUS && byteenable[0]
                      && !writedata[`DPW_BIT_CMP]) begin
            cmp_flag_q <= 1'b0;
         end
         cmp_irq        <= (cmp_flag_q | cmp_chg) & cmp_ie_q;
         wake_req       <= sleep_mode & cmp_ie_q & cmp_we_q & cmp_chg;
         cmp_output_oe  <= (pin_sel_q == `DPW_PIN_RESULT)
                           | (pin_sel_q == `DPW_PIN_INVERT);
         cmp_output_pin <= (pin_sel_q == `DPW_PIN_RESULT) ? cmp_res_q
                           : (pin_sel_q == `DPW_PIN_INVERT) & ~cmp_res_q;
      end
   end

   // Register writes
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int c = 0; c < 3; c++) begin
            ctl_q[c]    <= '0;
            period_q[c] <= `DPW_RST_ZERO;
            duty_q[c]   <= `DPW_RST_ZERO;
         end
         shdn_en_q <= 3'h0;
         dt_en_q   <= 3'h0;
         dt_psc_q  <= 2'h0;
         dt_val_q  <= 8'h00;
         clkdiv_q  <= 1'b0;
         pin_sel_q <= 2'h0;
         cmp_ie_q  <= 1'b0;
         cmp_we_q  <= 1'b0;
      end else if (wr_go) begin
         if (in_chan) begin
            unique case (sub)
               `DPW_SUB_CTRL:   if (byteenable[0]) ctl_q[ch] <= writedata[7:0];
               `DPW_SUB_PERIOD: begin
                  // High byte first; low byte commits
                  if (byteenable[0]) period_q[ch][7:0]  <= writedata[7:0];
                  if (byteenable[1]) period_q[ch][15:8] <= writedata[15:8];
               end
               `DPW_SUB_DUTY: begin
                  if (byteenable[0]) duty_q[ch][7:0]  <= writedata[7:0];
                  if (byteenable[1]) duty_q[ch][15:8] <= writedata[15:8];
               end
               `DPW_SUB_TIMER:  ; // Counter is read-only
            endcase
         end else if (byteenable[0]) begin
            unique case (idx)
               `DPW_IDX_WAKE:    cmp_we_q <= writedata[`DPW_BIT_CMP];
               `DPW_IDX_MASK:    cmp_ie_q <= writedata[`DPW_BIT_CMP];
               `DPW_IDX_CMP1: begin
                  pin_sel_q    <= writedata[`DPW_POS_PINSEL +: 2];
                  shdn_en_q[0] <= writedata[`DPW_BIT_SHDN];
               end
               `DPW_IDX_CMP2:    shdn_en_q[1] <= writedata[`DPW_BIT_SHDN];
               `DPW_IDX_CMP3:    shdn_en_q[2] <= writedata[`DPW_BIT_SHDN];
               `DPW_IDX_DEADCTL: begin
                  dt_en_q  <= writedata[`DPW_POS_DTEN +: 3];
                  dt_psc_q <= writedata[1:0];
               end
               `DPW_IDX_DEADVAL: dt_val_q <= writedata[7:0];
               `DPW_IDX_CLKDIV:  clkdiv_q <= writedata[0];
               default:          ; // Unmapped or flag register: nothing stored
            endcase
         end
      end
   end

   // Read multiplexer
   always_comb begin
      rd_val = 32'h0000_0000;
      if (in_chan) begin
         unique case (sub)
            `DPW_SUB_CTRL:   rd_val = {24'h000000, ctl_q[ch]};
            `DPW_SUB_PERIOD: rd_val = {16'h0000, period_q[ch]};
            `DPW_SUB_DUTY:   rd_val = {16'h0000, duty_q[ch]};
            `DPW_SUB_TIMER:  rd_val = {16'h0000, cnt_q[ch]};
         endcase
      end else begin
         unique case (idx)
            `DPW_IDX_WAKE:    rd_val[`DPW_BIT_CMP] = cmp_we_q;
            `DPW_IDX_STATUS:  rd_val[`DPW_BIT_CMP] = cmp_flag_q;
            `DPW_IDX_MASK:    rd_val[`DPW_BIT_CMP] = cmp_ie_q;
            `DPW_IDX_CMP1: begin
               rd_val[`DPW_BIT_CMP]       = cmp_res_q;
               rd_val[`DPW_POS_PINSEL +: 2] = pin_sel_q;
               rd_val[`DPW_BIT_SHDN]      = shdn_en_q[0];
            end
            `DPW_IDX_CMP2:    rd_val[`DPW_BIT_SHDN] = shdn_en_q[1];
            `DPW_IDX_CMP3:    rd_val[`DPW_BIT_SHDN] = shdn_en_q[2];
            `DPW_IDX_DEADCTL: rd_val[4:0] = {dt_en_q, dt_psc_q};
            `DPW_IDX_DEADVAL: rd_val[7:0] = dt_val_q;
            `DPW_IDX_FLAGS:   rd_val[6:0] = {match_flag_q, 1'b0, cycle_flag_q};
            `DPW_IDX_CLKDIV:  rd_val[0]   = clkdiv_q;
            default:          rd_val      = 32'h0000_0000;
         endcase
      end
   end

   // Read data captured in the wait cycle, stands at the release edge
   always_ff @(posedge clock) begin
      if (rst) begin
         readdata <= 32'h0000_0000;
      end else if (clk_en && read && !ack_q) begin
         readdata <= rd_val;
      end
   end

endmodule

// file: verif/dpw_top_assertions.sv
module dpw_chk (
   // System
   input wire logic        clock,
   input wire logic        rst,
   // Bus
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Comparator and pins
   input wire logic        sleep_mode,
   input wire logic        cmp_output_oe,
   input wire logic        cmp_irq,
   input wire logic        wake_req,
   input wire logic [2:0]  pwm_o,
   input wire logic [2:0]  pwm_oe,
   input wire logic [2:0]  pwm_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wr_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Recent write history
   always_ff @(posedge clock) begin
      wr_q <= rst ? 4'h0 : {wr_q[2:0], write};
   end
   property p_wait_first;
      (read || write) && !$past(read || write) |-> waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first)
      else $error("first request cycle not stalled");
   property p_wait_ack;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_wait_ack: assert property (p_wait_ack)
      else $error("request not answered after one cycle");
   property p_wait_idle;
      !(read || write) |-> !waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle)
      else $error("stall without request");
   property p_rst_out;
      $fell(rst) |-> {pwm_o, pwm_oe, pwm_n_oe, cmp_output_oe, cmp_irq, wake_req} == 12'h000;
   endproperty
   a_rst_out: assert property (p_rst_out)
      else $error("outputs not idle after reset");
   property p_rd_stand;
      $changed(readdata) |-> $past(read);
   endproperty
   a_rd_stand: assert property (p_rd_stand)
      else $error("read data moved without read");
   property p_irq_hold;
      $fell(cmp_irq) |-> wr_q != 4'h0;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped without write");
   property p_pin_oe;
      $changed(cmp_output_oe) |-> wr_q != 4'h0;
   endproperty
   a_pin_oe: assert property (p_pin_oe)
      else $error("comparator pin enable moved without write");
   property p_pwm_oe;
      $changed(pwm_oe) || $changed(pwm_n_oe) |-> wr_q != 4'h0;
   endproperty
   a_pwm_oe: assert property (p_pwm_oe)
      else $error("pwm enable moved without write");
   property p_wake;
      wake_req |-> $past(sleep_mode);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake outside sleep");
endmodule

bind dpw_top dpw_chk i_dpw_chk (.clock, .rst, .read, .write, .readdata, .waitrequest,
   .sleep_mode, .cmp_output_oe, .cmp_irq, .wake_req, .pwm_o, .pwm_oe, .pwm_n_oe);

// file: verif/dpw_load.sv
module dpw_load (
   // System
   input  wire logic        clock,
   input  wire logic        clr,
   // Active state of both outputs
   input  wire logic        pa,
   input  wire logic        pn,
   // Measurements
   output logic      [15:0] per_len,
   output logic      [15:0] hi_len,
   output logic      [15:0] both_cnt,
   output logic      [15:0] eq_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        pa_q;
   logic [15:0] run_c;
   logic [15:0] hi_c;
   // Period and active time of the normal output
   always_ff @(posedge clock) begin
      pa_q  <= pa;
      run_c <= (pa && !pa_q) ? 16'h0001 : run_c + 16'h0001;
      hi_c  <= (pa && !pa_q) ? 16'h0001 : hi_c + {15'h0000, pa};
      if (clr) begin
         per_len <= 16'h0000;
         hi_len  <= 16'h0000;
      end else begin
         if (pa && !pa_q) per_len <= run_c;
         if (!pa && pa_q) hi_len <= hi_c;
      end
   end
   // Overlap and gap counts
   always_ff @(posedge clock) begin
      both_cnt <= clr ? 16'h0000 : both_cnt + {15'h0000, pa & pn};
      eq_cnt   <= clr ? 16'h0000 : eq_cnt + {15'h0000, pa ~^ pn};
   end
endmodule

// file: verif/test_dpw_top.sv
module test_dpw_top;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
   logic        clock, rst, clk_en, read, write, cmp_in, sleep_mode, clr, al, ial;
   logic [8:0]  address;
   logic [3:0]  byteenable;
   logic [31:0] writedata, readdata, seed;
   logic        waitrequest, cmp_output_pin, cmp_output_oe, cmp_irq, wake_req;
   logic [2:0]  pwm_o, pwm_oe, pwm_n_o, pwm_n_oe;
   logic [1:0]  sel;
   logic [15:0] per_len, hi_len, both_cnt, eq_cnt, rd;
   int          error_cnt, checked;
   // Design and load
   dpw_top i_dpw_top (.clock, .rst, .clk_en, .address, .read, .write, .byteenable,
      .writedata, .readdata, .waitrequest, .cmp_in, .sleep_mode, .cmp_output_pin,
      .cmp_output_oe, .cmp_irq, .wake_req, .pwm_o, .pwm_oe, .pwm_n_o, .pwm_n_oe);
   // Released pins read as inactive at the load
   dpw_load i_dpw_load (.clock, .clr, .pa(pwm_oe[sel] & (pwm_o[sel] ~^ al)),
      .pn(pwm_n_oe[sel] & (pwm_n_o[sel] ~^ ial)), .per_len, .hi_len, .both_cnt, .eq_cnt);
   // Clock
   always #4 clock = ~clock;
   // Random source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Clocks per counter step
   function automatic int tick(input logic [2:0] p, input logic c);
      return (1 << p) * (c ? 2 : 1);
   endfunction
   // One bus access, held until the stall drops
   task automatic bus(input logic wr, input logic [6:0] idx, input logic [15:0] d,
                      input logic [1:0] be);
      @(posedge clock);
      address    <= {idx, 2'b00};
      writedata  <= {16'h0000, d};
      byteenable <= {2'b00, be};
      write      <= wr;
      read       <= !wr;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      rd = readdata[15:0];
      write <= 1'b0;
      read  <= 1'b0;
   endtask
   // Verdict
   task automatic summarize();
      $display("checked %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Watchdog: about four times the longest expected run
   initial begin
      #200000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      summarize();
   end
   // Main sequence
   initial begin
      int p, d, t, ch;
      logic [6:0] b;
      logic [2:0] ps;
      logic [5:0] on, pins;
      logic       cd, dt, w;
      error_cnt = 0; checked = 0; seed = 32'h0000a29a;
      clock = 1'b0; rst = 1'b1; clk_en = 1'b1; read = 1'b0; write = 1'b0; cmp_in = 1'b0;
      sleep_mode = 1'b0; clr = 1'b0; sel = 2'h0; al = 1'b1; ial = 1'b1;
      address = 9'h000; byteenable = 4'h0; writedata = 32'h00000000;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      bus(1'b0, 7'h44, 16'h0000, 2'h0); `CHK(rd, 16'h0000)
      bus(1'b1, 7'h43, 16'h1234, 2'h3);
      bus(1'b0, 7'h43, 16'h0000, 2'h0); `CHK(rd, 16'h0000)
      bus(1'b0, 7'h20, 16'h0000, 2'h0); `CHK(rd, 16'h0000)
      // Each channel set up, then retuned while running with dead time
      for (int i = 0; i < 6; i++) begin
         ch = i / 2; b = 7'(64 + 4 * ch); dt = (i % 2 == 1);
         p = 8 + int'(rnd() % 16); d = 4 + int'(rnd() % (p - 6));
         ps = 3'(rnd() % 3); cd = 1'(rnd() % 2); al = 1'(rnd() % 2); ial = 1'(rnd() % 2);
         sel <= 2'(ch); t = tick(ps, cd);
         bus(1'b1, b + 7'h2, 16'(d), 2'h3);
         bus(1'b1, 7'h51, 16'h0002, 2'h1);
         bus(1'b1, 7'h50, 16'(dt) << (2 + ch), 2'h1);
         bus(1'b1, b + 7'h1, 16'(p), 2'h2);
         bus(1'b1, b + 7'h1, 16'(p), 2'h1);
         bus(1'b1, 7'h53, 16'(cd), 2'h1);
         if (!dt) bus(1'b1, b, {8'h00, 2'b11, al, ial, 1'b0, ps}, 2'h1);
         bus(1'b1, b, {8'h00, 2'b11, al, ial, 1'b1, ps}, 2'h1);
         repeat (2 * (p + 1) * t + 8) @(posedge clock);
         clr <= 1'b1;
         @(posedge clock);
         clr <= 1'b0;
         repeat (3 * (p + 1) * t + 8) @(posedge clock);
         `CHK(per_len, 16'((p + 1) * t))
         if (dt) begin
            `CHK(both_cnt, 16'h0000)
            `CHK(eq_cnt != 16'h0000, 1'b1)
         end else begin
            `CHK(hi_len, 16'(d * t))
            `CHK(eq_cnt, 16'h0000)
         end
         bus(1'b0, b + 7'h3, 16'h0000, 2'h0); `CHK(rd <= 16'(p), 1'b1)
         bus(1'b0, 7'h52, 16'h0000, 2'h0); `CHK(rd[ch] & rd[ch + 4], 1'b1)
      end
      // Comparator flag, pin and shutdown on channel A
      al = 1'b1; ial = 1'b1; sel <= 2'h0;
      bus(1'b1, 7'h40, 16'h00f8, 2'h1);
      bus(1'b1, 7'h3a, 16'h0011, 2'h1);
      bus(1'b1, 7'h1b, 16'h0040, 2'h1);
      cmp_in <= 1'b1;
      repeat (4) @(posedge clock);
      `CHK(cmp_irq, 1'b1)
      `CHK({cmp_output_pin, cmp_output_oe}, 2'b11)
      bus(1'b0, 7'h3a, 16'h0000, 2'h0); `CHK(rd[6], 1'b1)
      repeat (20) @(posedge clock);
      bus(1'b0, 7'h14, 16'h0000, 2'h0); `CHK(rd[6], 1'b1)
      bus(1'b1, 7'h14, 16'h0000, 2'h1);
      bus(1'b0, 7'h14, 16'h0000, 2'h0); `CHK(rd[6], 1'b0)
      `CHK(cmp_irq, 1'b0)
      cmp_in <= 1'b0;
      repeat (4) @(posedge clock);
      on = 6'h00;
      repeat (32) begin
         @(posedge clock);
         on = on + {5'h00, pwm_o[0] | pwm_n_o[0]};
      end
      `CHK(on, 6'h00)
      // Wake from sleep on a comparator change
      bus(1'b1, 7'h10, 16'h0040, 2'h1);
      sleep_mode <= 1'b1;
      @(posedge clock);
      cmp_in <= 1'b1;
      w = 1'b0;
      repeat (8) begin
         @(posedge clock);
         if (wake_req === 1'b1) w = 1'b1;
      end
      `CHK(w, 1'b1)
      sleep_mode <= 1'b0;
      // Inverted result on the comparator pin
      bus(1'b1, 7'h3a, 16'h0020, 2'h1);
      repeat (2) @(posedge clock);
      `CHK({cmp_output_pin, cmp_output_oe}, 2'b01)
      // Clock enable low freezes the running channels' pins
      clk_en <= 1'b0;
      @(posedge clock);
      pins = {pwm_o, pwm_n_o};
      on = 6'h00;
      repeat (24) begin
         @(posedge clock);
         on = on + {5'h00, {pwm_o, pwm_n_o} != pins};
      end
      clk_en <= 1'b1;
      `CHK(on, 6'h00)
      summarize();
   end
endmodule
